/* File: rtl/adc_scan_diag_cfg.svh */
`ifndef ADC_SCAN_DIAG_CFG_SVH
`define ADC_SCAN_DIAG_CFG_SVH

// register offsets
`define OFS_SCAN_CONTROL        8'h10
`define OFS_MANUAL_CHANNEL      8'h11
`define OFS_SCAN_CH_ENABLES     8'h12
`define OFS_DIAG_UNLOCK         8'hBF
`define OFS_DIAG_CONTROL        8'hC0
`define OFS_SAMPLE_PHASE_LOW    8'hC1
`define OFS_SAMPLE_PHASE_HIGH   8'hC2

// field positions
`define POS_SCAN_MODE_LO        0
`define POS_SCAN_MODE_HI        1
`define POS_SEQUENCE_RUN        4
`define POS_CHID_LO             0
`define POS_CHID_HI             3
`define POS_CHID_RSVD           3
`define POS_DECISION_STEP       0
`define POS_TEST_VOLTAGE        4

// reset values
`define RST_SCAN_CONTROL        8'h00
`define RST_MANUAL_CHANNEL      8'h00
`define RST_SCAN_CH_ENABLES     8'h00
`define RST_DIAG_UNLOCK         8'h00
`define RST_DIAG_CONTROL        8'h00
`define RST_SAMPLE_PHASE_LOW    8'h00

// constants
`define DIAG_UNLOCK_KEY         8'h96
`define NUM_CHANNELS            8

`endif

/* File: rtl/adc_scan_diag_pkg.sv */
package adc_scan_diag_pkg;

    typedef enum logic [1:0] {
        SCAN_MANUAL   = 2'h0,
        SCAN_AUTO     = 2'h1,
        SCAN_ON_FLY   = 2'h2,
        SCAN_RESERVED = 2'h3
    } scan_mode_t;

    // gray order along idle -> scanning
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'h0,
        SEQ_SCAN = 2'h1
    } seq_state_t;

    typedef logic [7:0] reg_byte_t;
    typedef logic [2:0] channel_t;

endpackage : adc_scan_diag_pkg

/* File: rtl/adc_channel_scan_diag_regs.sv */
`timescale 1ns/1ps
`include "adc_scan_diag_cfg.svh"

// Function
// - scan mode field: 00 manual, 01 auto mask scan, 10 on-the-fly, 11 reserved
// - in auto mode the run bit starts ascending scan of enabled channels; clear stops
// - manual mode: codes 0 to 7 select input for next conversion; top bit reserved
// - each scan mask bit includes its input in the automatic scan when set, unless that channel is flagged as general-purpose I/O
// - writing 0x96 to the unlock key opens writes to 0xC0 and 0xC1; 0xC2 has no register and reads zero
// - test voltage route bit connects input six to the 1.8V test source
// - test voltage route has no effect while decision step mode is set
// - diagnostics control bit 0 switches converter decisions to bit-walk mode
// - low sampling-phase pattern defines bit positions 7 to 0 during sampling
// - low sampling-phase pattern has no effect while diagnostics are inactive
// - a channel flagged in the channel function selection acts as general-purpose I/O
module adc_channel_scan_diag_regs
    import adc_scan_diag_pkg::*;
(
    // clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           rst_n,
    // register access port
    input  wire logic                           reg_wr_en,
    input  wire logic                           reg_rd_en,
    input  wire logic [7:0]                     reg_addr,
    input  wire logic [7:0]                     reg_wr_data,
    output logic      [7:0]                     reg_rd_data,
    output logic                                reg_rd_valid,
    // converter side
    input  wire logic [7:0]                     gpio_channel_select,
    input  wire logic                           conv_done,
    output adc_scan_diag_pkg::scan_mode_t       scan_mode_select,
    output logic                                sequence_run,
    output adc_scan_diag_pkg::channel_t         conv_channel,
    output logic                                conv_channel_valid,
    output logic      [7:0]                     analog_inputs,
    // diagnostics
    output logic                                diagnostics_active,
    output logic                                test_voltage_route,
    output logic                                decision_step_mode,
    output logic      [7:0]                     sample_phase_bits
);
    import adc_scan_diag_pkg::*;

    // register storage
    reg_byte_t  scan_control_q, scan_control_d;
    reg_byte_t  manual_channel_q, manual_channel_d;
    reg_byte_t  scan_enables_q, scan_enables_d;
    reg_byte_t  diag_unlock_q, diag_unlock_d;
    reg_byte_t  diag_control_q, diag_control_d;
    reg_byte_t  phase_low_q, phase_low_d;
    reg_byte_t  rd_data_q, rd_data_d;
    logic       rd_valid_q, rd_valid_d;

    logic       unlocked;
    logic       wr_diag_ok;

    assign unlocked   = (diag_unlock_q == `DIAG_UNLOCK_KEY);
    assign wr_diag_ok = reg_wr_en && unlocked;

    always_comb begin
        scan_control_d   = scan_control_q;
        manual_channel_d = manual_channel_q;
        scan_enables_d   = scan_enables_q;
        diag_unlock_d    = diag_unlock_q;
        diag_control_d   = diag_control_q;
        phase_low_d      = phase_low_q;
        if (reg_wr_en) begin
            case (reg_addr)
                `OFS_SCAN_CONTROL: begin
                    // only mode and run bits are writable
                    scan_control_d = 8'h00;
                    scan_control_d[`POS_SCAN_MODE_HI:`POS_SCAN_MODE_LO] =
                        reg_wr_data[`POS_SCAN_MODE_HI:`POS_SCAN_MODE_LO];
                    scan_control_d[`POS_SEQUENCE_RUN] =
                        reg_wr_data[`POS_SEQUENCE_RUN];
                end
                `OFS_MANUAL_CHANNEL: begin
                    manual_channel_d = 8'h00;
                    manual_channel_d[`POS_CHID_HI:`POS_CHID_LO] =
                        reg_wr_data[`POS_CHID_HI:`POS_CHID_LO];
                end
                `OFS_SCAN_CH_ENABLES: begin
                    scan_enables_d = reg_wr_data;
                end
                `OFS_DIAG_UNLOCK: begin
                    diag_unlock_d = reg_wr_data;
                end
                default: begin
                end
            endcase
        end
        if (wr_diag_ok) begin
            case (reg_addr)
                `OFS_DIAG_CONTROL: begin
                    diag_control_d = 8'h00;
                    diag_control_d[`POS_TEST_VOLTAGE] =
                        reg_wr_data[`POS_TEST_VOLTAGE];
                    diag_control_d[`POS_DECISION_STEP] =
                        reg_wr_data[`POS_DECISION_STEP];
                end
                `OFS_SAMPLE_PHASE_LOW: begin
                    phase_low_d = reg_wr_data;
                end
                default: begin
                end
            endcase
        end
    end

    // read path, one cycle latency, unmapped reads zero
    always_comb begin
        rd_valid_d = reg_rd_en;
        rd_data_d  = 8'h00;
        if (reg_rd_en) begin
            case (reg_addr)
                `OFS_SCAN_CONTROL:     rd_data_d = scan_control_q;
                `OFS_MANUAL_CHANNEL:   rd_data_d = manual_channel_q;
                `OFS_SCAN_CH_ENABLES:  rd_data_d = scan_enables_q;
                `OFS_DIAG_UNLOCK:      rd_data_d = diag_unlock_q;
                `OFS_DIAG_CONTROL:     rd_data_d = diag_control_q;
                `OFS_SAMPLE_PHASE_LOW: rd_data_d = phase_low_q;
                default:               rd_data_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            scan_control_q   <= `RST_SCAN_CONTROL;
            manual_channel_q <= `RST_MANUAL_CHANNEL;
            scan_enables_q   <= `RST_SCAN_CH_ENABLES;
            diag_unlock_q    <= `RST_DIAG_UNLOCK;
            diag_control_q   <= `RST_DIAG_CONTROL;
            phase_low_q      <= `RST_SAMPLE_PHASE_LOW;
            rd_data_q        <= 8'h00;
            rd_valid_q       <= 1'b0;
        end else begin
            scan_control_q   <= scan_control_d;
            manual_channel_q <= manual_channel_d;
            scan_enables_q   <= scan_enables_d;
            diag_unlock_q    <= diag_unlock_d;
            diag_control_q   <= diag_control_d;
            phase_low_q      <= phase_low_d;
            rd_data_q        <= rd_data_d;
            rd_valid_q       <= rd_valid_d;
        end
    end

    // channel sequencer
    scan_mode_t mode;
    logic       run_bit;
    logic [7:0] eff_mask;
    logic [7:0] above_mask;
    seq_state_t state_q, state_d;
    channel_t   chan_q, chan_d;
    logic       chan_ok_q, chan_ok_d;
    logic [7:0] ain_q, ain_d;

    assign mode    = scan_mode_t'(scan_control_q[`POS_SCAN_MODE_HI:`POS_SCAN_MODE_LO]);
    assign run_bit = scan_control_q[`POS_SEQUENCE_RUN];

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_CHANNELS; gi++) begin : g_chan
            // gpio channels leave the analog scan
            assign eff_mask[gi]   = scan_enables_q[gi] & ~gpio_channel_select[gi];
            assign above_mask[gi] = eff_mask[gi] & (3'(gi) > chan_q);
        end
    endgenerate

    function automatic channel_t lowest_set(input logic [7:0] m);
        channel_t c;
        c = 3'h0;
        for (int i = `NUM_CHANNELS - 1; i >= 0; i--) begin
            if (m[i]) begin
                c = 3'(i);
            end
        end
        return c;
    endfunction

    always_comb begin
        state_d   = state_q;
        chan_d    = chan_q;
        chan_ok_d = chan_ok_q;
        ain_d     = ~gpio_channel_select;
        case (state_q)
            SEQ_IDLE: begin
                chan_ok_d = 1'b0;
                if (mode == SCAN_MANUAL) begin
                    chan_d    = manual_channel_q[2:0];
                    // reserved code or gpio channel gives no valid input
                    chan_ok_d = !manual_channel_q[`POS_CHID_RSVD] &&
                                !gpio_channel_select[manual_channel_q[2:0]];
                end else if (mode == SCAN_AUTO && run_bit && (eff_mask != 8'h00)) begin
                    state_d   = SEQ_SCAN;
                    chan_d    = lowest_set(eff_mask);
                    chan_ok_d = 1'b1;
                end
            end
            SEQ_SCAN: begin
                if (mode != SCAN_AUTO || !run_bit || (eff_mask == 8'h00)) begin
                    state_d   = SEQ_IDLE;
                    chan_ok_d = 1'b0;
                end else begin
                    chan_ok_d = eff_mask[chan_q];
                    if (conv_done) begin
                        // ascending order, wrap to the lowest enabled
                        chan_d    = (above_mask != 8'h00) ? lowest_set(above_mask)
                                                          : lowest_set(eff_mask);
                        chan_ok_d = 1'b1;
                    end
                end
            end
            default: begin
                state_d   = SEQ_IDLE;
                chan_ok_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q   <= SEQ_IDLE;
            chan_q    <= 3'h0;
            chan_ok_q <= 1'b0;
            ain_q     <= 8'h00;
        end else begin
            state_q   <= state_d;
            chan_q    <= chan_d;
            chan_ok_q <= chan_ok_d;
            ain_q     <= ain_d;
        end
    end

    // diagnostics outputs, registered from next register values
    logic       active_q, active_d;
    logic       route_q, route_d;
    logic       step_q, step_d;
    logic [7:0] phase_q, phase_d;

    always_comb begin
        active_d = (diag_unlock_d == `DIAG_UNLOCK_KEY);
        step_d   = diag_control_d[`POS_DECISION_STEP];
        route_d  = diag_control_d[`POS_TEST_VOLTAGE] && !step_d;
        phase_d  = active_d ? phase_low_d : 8'h00;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            active_q <= 1'b0;
            route_q  <= 1'b0;
            step_q   <= 1'b0;
            phase_q  <= 8'h00;
        end else begin
            active_q <= active_d;
            route_q  <= route_d;
            step_q   <= step_d;
            phase_q  <= phase_d;
        end
    end

    // mode and run mirrors straight from the control register
    assign scan_mode_select   = mode;
    assign sequence_run       = run_bit;
    assign conv_channel       = chan_q;
    assign conv_channel_valid = chan_ok_q;
    assign analog_inputs      = ain_q;
    assign diagnostics_active = active_q;
    assign test_voltage_route = route_q;
    assign decision_step_mode = step_q;
    assign sample_phase_bits  = phase_q;
    assign reg_rd_data        = rd_data_q;
    assign reg_rd_valid       = rd_valid_q;

    // checks
    a_locked_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_wr_en && !unlocked && reg_addr == `OFS_DIAG_CONTROL
        |=> $stable(diag_control_q))
        else $error("diag control changed while locked");

    a_unlock_opens: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_wr_en && unlocked && reg_addr == `OFS_SAMPLE_PHASE_LOW
        |=> phase_low_q == $past(reg_wr_data))
        else $error("unlocked write to phase pattern lost");

    a_route_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
        step_q |-> !route_q)
        else $error("test voltage routed during decision step mode");

    a_route_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
        route_q == (diag_control_q[`POS_TEST_VOLTAGE] && !diag_control_q[`POS_DECISION_STEP]))
        else $error("test voltage route disagrees with control");

    a_step_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
        step_q == diag_control_q[`POS_DECISION_STEP])
        else $error("decision step mode disagrees with control");

    a_phase_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sample_phase_bits == (unlocked ? phase_low_q : 8'h00))
        else $error("sample phase pattern not gated by diagnostics");

    a_manual_chan: assert property (@(posedge ref_clk) disable iff (!rst_n)
        mode == SCAN_MANUAL && state_q == SEQ_IDLE ##1 mode == SCAN_MANUAL
        |-> chan_ok_q == (!$past(manual_channel_q[3]) &&
                          !$past(gpio_channel_select[manual_channel_q[2:0]])))
        else $error("manual channel validity wrong");

    a_scan_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_q == SEQ_IDLE && mode == SCAN_AUTO && run_bit && eff_mask != 8'h00
        |=> state_q == SEQ_SCAN && eff_mask[chan_q])
        else $error("auto scan did not start on enabled channel");

    a_scan_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_q == SEQ_SCAN && !run_bit |=> state_q == SEQ_IDLE && !chan_ok_q)
        else $error("scan did not stop when run bit cleared");

    a_scan_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_q == SEQ_SCAN && conv_done && $stable(eff_mask) && mode == SCAN_AUTO && run_bit
        |=> eff_mask[chan_q] || !chan_ok_q)
        else $error("scan advanced to an excluded channel");

    a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        scan_control_q[7:5] == 3'h0 && manual_channel_q[7:4] == 4'h0)
        else $error("reserved bits not zero");

    c_unlock: cover property (@(posedge ref_clk) disable iff (!rst_n)
        !unlocked ##1 unlocked ##[1:20] route_q);
    c_scan_wrap: cover property (@(posedge ref_clk) disable iff (!rst_n)
        state_q == SEQ_SCAN && conv_done && above_mask == 8'h00);
    c_manual_ok: cover property (@(posedge ref_clk) disable iff (!rst_n)
        mode == SCAN_MANUAL && chan_ok_q);

endmodule // adc_channel_scan_diag_regs

/* File: verification/reg_host_model.sv */
`timescale 1ns/1ps

// host side of the register port: one request per call, driven at the falling edge
module reg_host_model (
    // clock
    input  wire logic       ref_clk,
    // register access port
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wr_data,
    input  wire logic [7:0] reg_rd_data,
    input  wire logic       reg_rd_valid
);
    initial begin
        reg_wr_en   = 1'b0;
        reg_rd_en   = 1'b0;
        reg_addr    = 8'h00;
        reg_wr_data = 8'h00;
    end

    // released lines show the inverse so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_wr_en   = 1'b1;
        reg_addr    = a;
        reg_wr_data = d;
        @(negedge ref_clk);
        reg_wr_en   = 1'b0;
        reg_addr    = ~a;
        reg_wr_data = ~d;
    endtask

    // answer stands for the one cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge ref_clk);
        reg_rd_en = 1'b1;
        reg_addr  = a;
        @(negedge ref_clk);
        reg_rd_en = 1'b0;
        reg_addr  = ~a;
        d         = reg_rd_data;
        v         = reg_rd_valid;
    endtask
endmodule // reg_host_model

/* File: verification/adc_channel_scan_diag_regs_tb.sv */
`timescale 1ns/1ps

module adc_channel_scan_diag_regs_tb;
    import adc_scan_diag_pkg::*;

    logic       ref_clk, rst_n, reg_wr_en, reg_rd_en, reg_rd_valid, conv_done, rval;
    logic       sequence_run, conv_channel_valid, diagnostics_active;
    logic       test_voltage_route, decision_step_mode;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, gpio_channel_select, analog_inputs;
    logic [7:0] sample_phase_bits, rdat, mask, gpio, eff, pat;
    logic [2:0] ch;
    scan_mode_t scan_mode_select;
    channel_t   conv_channel;
    int         failures, tests_run;
    logic [7:0] addrs [8] = '{8'h10, 8'h11, 8'h12, 8'hBF, 8'hC0, 8'hC1, 8'hC2, 8'h55};

    adc_channel_scan_diag_regs i_adc_channel_scan_diag_regs (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid), .gpio_channel_select(gpio_channel_select),
        .conv_done(conv_done), .scan_mode_select(scan_mode_select),
        .sequence_run(sequence_run), .conv_channel(conv_channel),
        .conv_channel_valid(conv_channel_valid), .analog_inputs(analog_inputs),
        .diagnostics_active(diagnostics_active), .test_voltage_route(test_voltage_route),
        .decision_step_mode(decision_step_mode), .sample_phase_bits(sample_phase_bits));

    reg_host_model i_reg_host_model (
        .ref_clk(ref_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid));

    always #12.5 ref_clk = ~ref_clk;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        i_reg_host_model.rd(a, rdat, rval);
        chk({7'h00, rval}, 8'h01);
        chk(rdat, exp);
    endtask

    // next enabled channel above c, wrapping to the lowest
    function automatic logic [2:0] next_ch(input logic [7:0] m, input logic [2:0] c);
        logic [2:0] j;
        next_ch = c;
        for (int i = 8; i >= 1; i--) begin
            j = c + 3'(i);
            if (m[j])
                next_ch = j;
        end
    endfunction

    task automatic conclude;
        $display("counts: tests_run=%0d failures=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        conclude();
    end

    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        conv_done = 1'b0;
        gpio_channel_select = 8'h00;
        failures = 0;
        tests_run = 0;
        mask = 8'($urandom(44013));
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        foreach (addrs[i]) rchk(addrs[i], 8'h00);
        // manual mode on channel zero is usable out of reset
        chk({sequence_run, conv_channel_valid, diagnostics_active, test_voltage_route,
             decision_step_mode, 1'b0, scan_mode_select}, 8'h40);
        $display("test reset values done");
        for (int m = 0; m < 4; m++) begin
            i_reg_host_model.wr(8'h10, 8'hFC | 8'(m));
            chk({3'h0, sequence_run, 2'h0, scan_mode_select}, 8'h10 | 8'(m));
            rchk(8'h10, 8'h10 | 8'(m));
        end
        $display("test scan mode field done");
        i_reg_host_model.wr(8'h10, 8'h00);
        for (int k = 0; k < 16; k++) begin
            gpio = 8'($urandom) & 8'($urandom);
            gpio_channel_select = gpio;
            i_reg_host_model.wr(8'h11, 8'hF0 | 8'(k));
            // channel follows the register one edge later
            @(negedge ref_clk);
            chk({5'h00, conv_channel}, 8'(k & 7));
            chk({7'h00, conv_channel_valid}, {7'h00, k < 8 && !gpio[k & 7]});
            chk(analog_inputs, ~gpio);
            rchk(8'h11, 8'(k));
        end
        $display("test manual channel done");
        for (int n = 0; n < 12; n++) begin
            mask = (n == 0) ? 8'h81 : 8'($urandom);
            gpio = (n < 2) ? 8'h00 : 8'($urandom) & 8'($urandom);
            gpio_channel_select = gpio;
            eff = mask & ~gpio;
            i_reg_host_model.wr(8'h12, mask);
            i_reg_host_model.wr(8'h10, 8'h11);
            @(negedge ref_clk);
            ch = next_ch(eff, 3'h7);
            chk({7'h00, conv_channel_valid}, {7'h00, eff != 8'h00});
            if (eff != 8'h00)
                chk({5'h00, conv_channel}, {5'h00, ch});
            conv_done = 1'b1;
            for (int s = 0; s < 9; s++) begin
                @(negedge ref_clk);
                ch = next_ch(eff, ch);
                if (eff != 8'h00)
                    chk({5'h00, conv_channel}, {5'h00, ch});
            end
            conv_done = 1'b0;
            i_reg_host_model.wr(8'h10, n[0] ? 8'h01 : 8'h12);
            @(negedge ref_clk);
            chk({7'h00, conv_channel_valid}, 8'h00);
        end
        $display("test auto scan done");
        pat = 8'($urandom) | 8'h01;
        i_reg_host_model.wr(8'hC0, 8'h11);
        i_reg_host_model.wr(8'hBF, 8'h95);
        i_reg_host_model.wr(8'hC1, pat);
        chk({diagnostics_active, decision_step_mode, test_voltage_route, 5'h00}, 8'h00);
        rchk(8'hC0, 8'h00);
        rchk(8'hC1, 8'h00);
        i_reg_host_model.wr(8'hBF, 8'h96);
        chk({7'h00, diagnostics_active}, 8'h01);
        i_reg_host_model.wr(8'hC0, 8'hFE);
        chk({decision_step_mode, test_voltage_route, 6'h00}, 8'h40);
        rchk(8'hC0, 8'h10);
        i_reg_host_model.wr(8'hC0, 8'h11);
        chk({decision_step_mode, test_voltage_route, 6'h00}, 8'h80);
        i_reg_host_model.wr(8'hC1, pat);
        chk(sample_phase_bits, pat);
        rchk(8'hC1, pat);
        i_reg_host_model.wr(8'hC2, 8'h5A);
        rchk(8'hC2, 8'h00);
        i_reg_host_model.wr(8'hBF, 8'h00);
        chk(sample_phase_bits, 8'h00);
        i_reg_host_model.wr(8'hC1, ~pat);
        rchk(8'hC1, pat);
        $display("test diagnostics lock done");
        rst_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        rchk(8'hC0, 8'h00);
        chk({7'h00, decision_step_mode}, 8'h00);
        $display("test second reset done");
        conclude();
    end
endmodule // adc_channel_scan_diag_regs_tb
